// ### ccs_cfg.svh
// Constants for the CPU clock select block
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH
`define CCS_CCR_ADDR 16'hFFFB
`define CCS_CCR_RESET 8'h04
`define CCS_BIT_STOP 7
`define CCS_BIT_STATUS 5
`define CCS_BIT_SRC 4
`define CCS_BIT_RSV3 3
`define CCS_BIT_RSV6 6
`define CCS_DIV_LSB 0
`define CCS_DIV_MSB 2
`define CCS_DIV_MAX 3'h4
`define CCS_SUB_DIV_SEL 3'h1
`endif

// ### ccs_pkg.sv
// Types for the CPU clock select block
`default_nettype none
package ccs_pkg;
  typedef enum logic [1:0] {
    CCS_SRC_MAIN,
    CCS_SRC_SWITCH,
    CCS_SRC_SUB
  } ccs_src_e;
  typedef logic [2:0] ccs_div_t;
endpackage
`default_nettype wire

// ### ccs_pow2_div.sv
// Power-of-two enable divider producing one-cycle tick pulses
`timescale 1ns/100ps
`default_nettype none
module ccs_pow2_div #(
  parameter int MAX_SEL = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Source tick and division select
  input wire logic i_tick,
  input wire logic [2:0] i_sel,
  // Divided tick
  output logic o_tick
);
  logic [MAX_SEL-1:0] cnt_ff;
  logic [MAX_SEL-1:0] nxt_cnt;
  logic [MAX_SEL-1:0] mask;
  logic nxt_tick;
  logic o_tick_ff;

  always_comb begin
    mask = (MAX_SEL)'((1 << i_sel) - 1);
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (i_tick) begin
      // Terminal count reached when all masked bits are set
      if ((cnt_ff & mask) == mask) begin
        nxt_cnt = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_ff <= '0;
      o_tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      o_tick_ff <= nxt_tick;
    end
  end

  assign o_tick = o_tick_ff;
endmodule // ccs_pow2_div
`default_nettype wire

// ### ccs_clock_ctrl.sv
// CPU clock source select, division and main oscillator control
// Function
// RULE1 - Reset loads the control register with 04H, main clock divided by sixteen, oscillator running.
// RULE2 - The control register accepts single-bit and whole-byte CPU writes.
// RULE3 - With source select 0, division codes 0 to 4 give main clock divided by 1, 2, 4, 8, 16.
// RULE4 - With source select 1, any valid division code gives the subsystem clock divided by two.
// RULE5 - Bit 7 at 0 lets the main oscillator run and at 1 requests it to stop.
// RULE6 - Software writes zero to bit 3, and bits 6 and 3 are fixed zero.
// RULE7 - One minimum instruction time equals two periods of the selected CPU clock.
// RULE8 - A stopped main oscillator halts main clock operation and pulls the output pin up.
// RULE9 - With an external main clock software never stops the main oscillator.
// RULE10 - An external main clock drives the clock on the input pin and its inverse on the output pin.
// RULE11 - Bit 5 reads 0 on the main clock and 1 on the subsystem clock.
// RULE12 - A stop request on the main clock waits until the CPU has switched to the subsystem clock.
// RULE13 - Software never writes division codes 101, 110 or 111.
// RULE14 - The status bit is read-only and ignores CPU writes.
`timescale 1ns/100ps
`default_nettype none
`include "ccs_cfg.svh"
module ccs_clock_ctrl #(
  parameter int DIV_STAGES = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Oscillator ticks, one cycle each source edge
  input wire logic i_main_osc_tick,
  input wire logic i_sub_osc_tick,
  // STOP instruction request, level
  input wire logic i_stop_instr,
  // CPU register port
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_bit_wr,
  input wire logic [2:0] i_bit_idx,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Clock outputs
  output logic o_cpu_clk_tick,
  output logic o_instr_tick,
  output logic o_main_osc_en,
  output logic o_main_osc_out_pullup,
  output logic o_active_clock_status
);
  // Reset image, so every writable field reset comes from one constant
  localparam logic [7:0] CCR_RST = `CCS_CCR_RESET;
  logic main_osc_stop_ff, nxt_main_osc_stop;
  logic clock_source_select_ff, nxt_clock_source_select;
  ccs_pkg::ccs_div_t div_sel_ff, nxt_div_sel;
  ccs_pkg::ccs_src_e src_ff, nxt_src;
  logic [7:0] rdata_ff, nxt_rdata;
  logic osc_en_ff, nxt_osc_en;
  logic pullup_ff, nxt_pullup;
  logic cpu_tick_ff, nxt_cpu_tick;
  logic phase_ff, nxt_phase;
  logic instr_ff, nxt_instr;
  logic [7:0] reg_view;
  logic [7:0] wr_val;
  logic hit_wr;
  logic main_tick_gated;
  logic main_div_tick;
  logic sub_div_tick;
  logic on_sub;

  assign on_sub = (src_ff == ccs_pkg::CCS_SRC_SUB);
  assign main_tick_gated = i_main_osc_tick & osc_en_ff;

  always_comb begin
    reg_view = 8'h00;
    reg_view[`CCS_BIT_STOP] = main_osc_stop_ff;
    reg_view[`CCS_BIT_STATUS] = on_sub;
    reg_view[`CCS_BIT_SRC] = clock_source_select_ff;
    reg_view[`CCS_DIV_MSB:`CCS_DIV_LSB] = div_sel_ff;
  end

  // RULE2 bit or byte
  always_comb begin
    hit_wr = (i_wr || i_bit_wr) && (i_addr == `CCS_CCR_ADDR);
    wr_val = reg_view;
    if (i_wr) begin
      wr_val = i_wdata;
    end else if (i_bit_wr) begin
      wr_val[i_bit_idx] = i_wdata[0];
    end
  end

  // Control register next state
  always_comb begin
    nxt_main_osc_stop = main_osc_stop_ff;
    nxt_clock_source_select = clock_source_select_ff;
    nxt_div_sel = div_sel_ff;
    nxt_rdata = rdata_ff;
    if (hit_wr) begin
      // RULE5 stop request
      nxt_main_osc_stop = wr_val[`CCS_BIT_STOP];
      nxt_clock_source_select = wr_val[`CCS_BIT_SRC];
      // Prohibited codes are ignored so the divider never sees them
      if (wr_val[`CCS_DIV_MSB:`CCS_DIV_LSB] <= `CCS_DIV_MAX) begin
        nxt_div_sel = wr_val[`CCS_DIV_MSB:`CCS_DIV_LSB];
      end
      // RULE14 status ignores writes
    end
    if (i_rd && i_addr == `CCS_CCR_ADDR) begin
      // RULE6 fixed zero bits
      nxt_rdata = reg_view;
    end
  end

  // Source switch state machine
  always_comb begin
    nxt_src = src_ff;
    unique case (src_ff)
      ccs_pkg::CCS_SRC_MAIN: begin
        if (clock_source_select_ff) begin
          nxt_src = ccs_pkg::CCS_SRC_SWITCH;
        end
      end
      ccs_pkg::CCS_SRC_SWITCH: begin
        // Hand over on a subsystem edge so no runt CPU clock occurs
        if (!clock_source_select_ff) begin
          nxt_src = ccs_pkg::CCS_SRC_MAIN;
        end else if (i_sub_osc_tick) begin
          nxt_src = ccs_pkg::CCS_SRC_SUB;
        end
      end
      ccs_pkg::CCS_SRC_SUB: begin
        // Returning needs the main oscillator stop bit cleared again
        if (!clock_source_select_ff && !main_osc_stop_ff) begin
          nxt_src = ccs_pkg::CCS_SRC_MAIN;
        end
      end
    endcase
  end

  // Oscillator control and CPU clock
  always_comb begin
    // RULE12 stop only on sub
    // RULE8 halt and pull up
    nxt_osc_en = !((main_osc_stop_ff && on_sub) || (i_stop_instr && !on_sub));
    nxt_pullup = !nxt_osc_en;
    // RULE3 main divided
    // RULE4 sub divided by two
    nxt_cpu_tick = on_sub ? sub_div_tick : (main_div_tick && (src_ff == ccs_pkg::CCS_SRC_MAIN));
    // RULE7 two CPU clocks
    nxt_phase = phase_ff;
    nxt_instr = 1'b0;
    if (cpu_tick_ff) begin
      nxt_phase = !phase_ff;
      nxt_instr = phase_ff;
    end
  end

  ccs_pow2_div #(
    .MAX_SEL(DIV_STAGES)
  ) u_main_div (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_tick(main_tick_gated),
    .i_sel(div_sel_ff),
    .o_tick(main_div_tick)
  );

  ccs_pow2_div #(
    .MAX_SEL(DIV_STAGES)
  ) u_sub_div (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_tick(i_sub_osc_tick),
    .i_sel(`CCS_SUB_DIV_SEL),
    .o_tick(sub_div_tick)
  );

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      // RULE1 reset value
      main_osc_stop_ff <= CCR_RST[`CCS_BIT_STOP];
      clock_source_select_ff <= CCR_RST[`CCS_BIT_SRC];
      div_sel_ff <= CCR_RST[`CCS_DIV_MSB:`CCS_DIV_LSB];
      src_ff <= ccs_pkg::CCS_SRC_MAIN;
      rdata_ff <= 8'h00;
      osc_en_ff <= 1'b1;
      pullup_ff <= 1'b0;
      cpu_tick_ff <= 1'b0;
      phase_ff <= 1'b0;
      instr_ff <= 1'b0;
    end else begin
      main_osc_stop_ff <= nxt_main_osc_stop;
      clock_source_select_ff <= nxt_clock_source_select;
      div_sel_ff <= nxt_div_sel;
      src_ff <= nxt_src;
      rdata_ff <= nxt_rdata;
      osc_en_ff <= nxt_osc_en;
      pullup_ff <= nxt_pullup;
      cpu_tick_ff <= nxt_cpu_tick;
      phase_ff <= nxt_phase;
      instr_ff <= nxt_instr;
    end
  end

  // RULE11 status bit
  logic status_ff;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      status_ff <= 1'b0;
    end else begin
      status_ff <= on_sub;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_cpu_clk_tick = cpu_tick_ff;
  assign o_instr_tick = instr_ff;
  assign o_main_osc_en = osc_en_ff;
  assign o_main_osc_out_pullup = pullup_ff;
  assign o_active_clock_status = status_ff;
endmodule // ccs_clock_ctrl
`default_nettype wire

// ### ccs_clock_ctrl_props.sv
// Port assertions for the CPU clock select block
`timescale 1ns/100ps
`default_nettype none
module ccs_clock_ctrl_chk (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Inputs
  input wire logic i_stop_instr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  // Outputs
  input wire logic [7:0] o_rdata,
  input wire logic o_cpu_clk_tick,
  input wire logic o_instr_tick,
  input wire logic o_main_osc_en,
  input wire logic o_main_osc_out_pullup,
  input wire logic o_active_clock_status
);
  default clocking dc @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);
  instr_pair_a: assert property (o_instr_tick |-> $past(o_cpu_clk_tick))
    else $error("instr tick not after cpu tick");
  pin_pullup_a: assert property (o_main_osc_out_pullup != o_main_osc_en)
    else $error("pull-up disagrees with osc state");
  // Three cycles let ticks already in the divider pipe drain
  main_halt_a: assert property ((!o_main_osc_en && !o_active_clock_status)[*3] |-> !o_cpu_clk_tick)
    else $error("cpu tick with main osc stopped");
  stop_instr_a: assert property ($rose(i_stop_instr) && !o_active_clock_status |-> ##[1:4] !o_main_osc_en)
    else $error("stop instruction left osc running");
  stop_wait_a: assert property ($fell(o_main_osc_en) && !$past(i_stop_instr) |-> o_active_clock_status)
    else $error("osc stopped before switch to sub");
  read_hold_a: assert property (!$past(i_rd) |-> $stable(o_rdata))
    else $error("read data changed without read");
  status_read_a: assert property ($past(i_rd && i_addr == 16'hFFFB) |-> o_rdata[5] == o_active_clock_status)
    else $error("status bit read disagrees with status");
  fixed_zero_a: assert property (!o_rdata[6] && !o_rdata[3])
    else $error("fixed zero bit read as one");
endmodule // ccs_clock_ctrl_chk
bind ccs_clock_ctrl ccs_clock_ctrl_chk i_ccs_clock_ctrl_chk (.i_clk_sys, .i_rstn, .i_stop_instr, .i_rd, .i_addr,
  .o_rdata, .o_cpu_clk_tick, .o_instr_tick, .o_main_osc_en, .o_main_osc_out_pullup, .o_active_clock_status);
`default_nettype wire

// ### test_cpu_clock_select_control.sv
// Self-checking bench for the CPU clock select block
`timescale 1ns/100ps
`default_nettype none
module test_cpu_clock_select_control;
  logic clk, rstn, stp, wr, bwr, rd, cpu, ins, osc, pu, sts;
  logic mtk = 1'b0;
  logic stk = 1'b0;
  logic [15:0] addr;
  logic [7:0] wd, rdat;
  logic [2:0] bidx;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  ccs_clock_ctrl i_ccs_clock_ctrl (
    .i_clk_sys(clk), .i_rstn(rstn), .i_main_osc_tick(mtk), .i_sub_osc_tick(stk), .i_stop_instr(stp),
    .i_addr(addr), .i_wr(wr), .i_bit_wr(bwr), .i_bit_idx(bidx), .i_wdata(wd), .i_rd(rd), .o_rdata(rdat),
    .o_cpu_clk_tick(cpu), .o_instr_tick(ins), .o_main_osc_en(osc), .o_main_osc_out_pullup(pu),
    .o_active_clock_status(sts));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // Sub ticks every 12 cycles so a sub CPU period never equals a main one
  // main ticks come every second cycle, on odd cycle counts
  always @(posedge clk) begin
    #1;
    cyc = cyc + 1;
    mtk = cyc[0];
    stk = (cyc % 12 == 0);
  end
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr8(logic [15:0] a, logic [7:0] d);
    {addr, wd, wr} = {a, d, 1'b1};
    step();
    wr = 0;
    step();
  endtask
  task automatic wrb(logic [2:0] i, logic v);
    {bidx, wd, bwr} = {i, 7'h00, v, 1'b1};
    step();
    bwr = 0;
    step();
  endtask
  task automatic rdc(logic [7:0] exp, string what);
    {addr, rd} = {16'hFFFB, 1'b1};
    step();
    rd = 0;
    step();
    chk(rdat, exp, what);
  endtask
  function automatic logic pick(logic [1:0] w);
    return w[1] ? sts ^ w[0] : (w[0] ? ins : cpu);
  endfunction
  task automatic wt(logic [1:0] w);
    int n;
    for (n = 0; n < 300 && pick(w) !== 1'b1; n++)
      step();
    if (n == 300) begin
      err_total++;
      $display("FAIL %0t wait bound used up", $time);
      wrap_up();
    end
  endtask
  task automatic gap(logic w, logic [7:0] exp, string what);
    int n;
    wt({1'b0, w});
    step();
    wt({1'b0, w});
    n = 0;
    do begin
      step();
      n++;
    end while (n < 300 && pick({1'b0, w}) !== 1'b1);
    chk(8'(n), exp, what);
  endtask
  task automatic t_reset();
    rdc(8'h04, "reset value");
    chk({6'h0, osc, pu}, 8'h02, "osc after reset");
    wr8(16'hFFFA, 8'h10);
    rdc(8'h04, "unmapped write");
  endtask
  task automatic t_div();
    for (int d = 0; d < 5; d++) begin
      wr8(16'hFFFB, 8'(d));
      gap(0, 8'(2 << d), "main cpu period");
    end
    gap(1, 8'h40, "main instr period");
    wr8(16'hFFFB, 8'h64);
    rdc(8'h04, "refused bits");
  endtask
  task automatic t_sub();
    wrb(3'h4, 1'b1);
    wt(2'h2);
    rdc(8'h34, "sub status");
    for (int d = 0; d < 5; d++) begin
      wr8(16'hFFFB, 8'h10 | 8'(d));
      gap(0, 8'h18, "sub cpu period");
    end
    gap(1, 8'h30, "sub instr period");
  endtask
  task automatic t_stop();
    // main source is a resonator here, so stopping it is allowed
    wrb(3'h7, 1'b1);
    step(4);
    chk({6'h0, osc, pu}, 8'h01, "stopped on sub");
    wr8(16'hFFFB, 8'h84);
    step(40);
    rdc(8'hA4, "return blocked");
    wrb(3'h7, 1'b0);
    wt(2'h3);
    step(4);
    chk({6'h0, osc, pu}, 8'h02, "osc restarted");
    wr8(16'hFFFB, 8'h84);
    step(40);
    chk({6'h0, osc, sts}, 8'h02, "stop bit on main");
    wrb(3'h4, 1'b1);
    wt(2'h2);
    step(2);
    chk({6'h0, osc, pu}, 8'h01, "stopped after switch");
    wr8(16'hFFFB, 8'h14);
    wr8(16'hFFFB, 8'h04);
    wt(2'h3);
  endtask
  task automatic t_stpi();
    stp = 1;
    step(6);
    chk({6'h0, osc, pu}, 8'h01, "stop instruction");
    stp = 0;
    step(6);
    chk({6'h0, osc, pu}, 8'h02, "stop released");
    gap(0, 8'h20, "clock resumed");
  endtask
  initial begin
    {rstn, stp, wr, bwr, rd, addr, wd, bidx} = 0;
    step(4);
    rstn = 1;
    t_reset();
    t_div();
    t_sub();
    t_stop();
    t_stpi();
    wrap_up();
  end
endmodule // test_cpu_clock_select_control
`default_nettype wire
